// ### hw/gsc_top.sv
// Game start, mode control, score counting and score video overlay
`include "gsc_consts.svh"
module gsc_top (
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire logic                   btn_make_n,
	input  wire logic                   btn_break_n,
	input  wire logic                   credit_ok,
	input  wire logic                   point_vs_right,
	input  wire logic                   point_vs_left,
	input  wire logic                   limit_closed,
	input  wire gsc_pkg::gsc_beam_t     beam,
	input  wire logic                   net_video,
	output logic                        game_start,
	output logic                        demo_mode,
	output logic                        play_mode,
	output logic                        game_over,
	output logic                        score_window,
	output logic                [6:0]   seg,
	output logic                        score_video
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [5:0] pins_s;
	logic       make_s;
	logic       break_s;
	logic       credit_s;
	logic       pt_right_s;
	logic       pt_left_s;
	logic       limit_s;

	gsc_sync #(
		.WIDTH(6)
	) u_sync (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in ({~btn_make_n, ~btn_break_n, credit_ok, point_vs_right, point_vs_left, limit_closed}),
		.sync_out (pins_s)
	);

	assign {make_s, break_s, credit_s, pt_right_s, pt_left_s, limit_s} = pins_s;

	////////////////////////////////////////////////////////////////////////
	// Button latch and gated start pulse
	logic btn_latch_reg;
	logic gated_prev_reg;
	logic gated_pulse;
	logic trail_strobe;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			btn_latch_reg <= 1'b0;
		end else if (make_s) begin
			btn_latch_reg <= 1'b1;
		end else if (break_s) begin
			btn_latch_reg <= 1'b0;
		end
	end

	assign gated_pulse = btn_latch_reg & credit_s;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			gated_prev_reg <= 1'b0;
		end else begin
			gated_prev_reg <= gated_pulse;
		end
	end

	// Trailing edge of the gated pulse
	assign trail_strobe = gated_prev_reg & ~gated_pulse;

	////////////////////////////////////////////////////////////////////////
	// Pending start, start register, mode flag
	gsc_pkg::gsc_mode_t mode_reg;
	logic               pending_reg;
	logic               start_reg;
	logic               start_prev_reg;
	logic               vbit_prev_reg;
	logic               vbit_rise;
	logic               start_rise;
	logic               over_reg;
	logic               over_prev_reg;
	logic               over_rise;
	logic               over_next;

	assign vbit_rise  = beam.vcount[`GSC_VSTART_BIT] & ~vbit_prev_reg;
	assign start_rise = start_reg & ~start_prev_reg;
	assign over_rise  = over_reg & ~over_prev_reg;

	// Set wins over the clear by the start register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pending_reg <= 1'b0;
		end else if (trail_strobe) begin
			pending_reg <= (mode_reg == gsc_pkg::GSC_DEMO);
		end else if (start_reg) begin
			pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			start_reg <= 1'b0;
		end else if (vbit_rise) begin
			start_reg <= pending_reg;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			vbit_prev_reg  <= 1'b0;
			start_prev_reg <= 1'b0;
			over_prev_reg  <= 1'b0;
		end else begin
			vbit_prev_reg  <= beam.vcount[`GSC_VSTART_BIT];
			start_prev_reg <= start_reg;
			over_prev_reg  <= over_reg;
		end
	end

	// Start edge, not level: start stands a frame and would undo game over
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mode_reg <= gsc_pkg::GSC_DEMO;
		end else if (over_rise) begin
			mode_reg <= gsc_pkg::GSC_DEMO;
		end else if (start_rise && credit_s) begin
			mode_reg <= gsc_pkg::GSC_PLAY;
		end
	end

	assign game_start = start_reg;
	assign demo_mode  = (mode_reg == gsc_pkg::GSC_DEMO);
	assign play_mode  = (mode_reg == gsc_pkg::GSC_PLAY);
	assign game_over  = over_reg;

	////////////////////////////////////////////////////////////////////////
	// Score counters
	logic                pt_right_prev_reg;
	logic                pt_left_prev_reg;
	logic                left_point;
	logic                right_point;
	gsc_pkg::gsc_score_t left_score;
	gsc_pkg::gsc_score_t right_score;
	logic          [3:0] left_tens_code;
	logic          [3:0] right_tens_code;
	logic                left_hit;
	logic                right_hit;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pt_right_prev_reg <= 1'b0;
			pt_left_prev_reg  <= 1'b0;
		end else begin
			pt_right_prev_reg <= pt_right_s;
			pt_left_prev_reg  <= pt_left_s;
		end
	end

	assign left_point  = pt_right_s & ~pt_right_prev_reg & play_mode;
	assign right_point = pt_left_s & ~pt_left_prev_reg & play_mode;

	gsc_score u_left (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.clear      (start_rise),
		.point      (left_point),
		.limit_high (limit_s),
		.score      (left_score),
		.tens_code  (left_tens_code),
		.limit_hit  (left_hit)
	);

	gsc_score u_right (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.clear      (start_rise),
		.point      (right_point),
		.limit_high (limit_s),
		.score      (right_score),
		.tens_code  (right_tens_code),
		.limit_hit  (right_hit)
	);

	assign over_next = left_hit | right_hit;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			over_reg <= 1'b0;
		end else begin
			over_reg <= over_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Score window, digit select, decoder, segment gating
	logic       v_band;
	logic       left_area;
	logic       right_area;
	logic       window_c;
	logic [3:0] digit;
	logic [6:0] seg_c;
	logic [2:0] row;
	logic       col_left;
	logic       col_right;
	logic       upper;
	logic       pixel_c;

	assign v_band     = (beam.vcount >= `GSC_SCORE_V_START) && (beam.vcount < `GSC_SCORE_V_END);
	assign left_area  = (beam.hcount >= `GSC_LEFT_H_START) && (beam.hcount < `GSC_LEFT_H_END);
	assign right_area = (beam.hcount >= `GSC_RIGHT_H_START) && (beam.hcount < `GSC_RIGHT_H_END);
	assign window_c   = v_band && (left_area || right_area);

	always_comb begin
		case (gsc_pkg::gsc_digit_sel_t'({beam.hcount[`GSC_SEL_HI_BIT], beam.hcount[`GSC_SEL_LO_BIT]}))
			gsc_pkg::GSC_SEL_LEFT_TENS:   digit = left_tens_code;
			gsc_pkg::GSC_SEL_LEFT_UNITS:  digit = left_score.units;
			gsc_pkg::GSC_SEL_RIGHT_TENS:  digit = right_tens_code;
			default:                      digit = right_score.units;
		endcase
	end

	// Segment order {a,b,c,d,e,f,g}; codes above nine are blank
	always_comb begin
		seg_c = `GSC_SEG_OFF;
		if (window_c) begin
			case (digit)
				4'h0:    seg_c = 7'h7E;
				4'h1:    seg_c = 7'h30;
				4'h2:    seg_c = 7'h6D;
				4'h3:    seg_c = 7'h79;
				4'h4:    seg_c = 7'h33;
				4'h5:    seg_c = 7'h5B;
				4'h6:    seg_c = 7'h5F;
				4'h7:    seg_c = 7'h70;
				4'h8:    seg_c = 7'h7F;
				4'h9:    seg_c = 7'h7B;
				default: seg_c = `GSC_SEG_OFF;
			endcase
		end
	end

	// Digit drawn in the left 16 columns of each 32-wide cell
	assign row       = beam.vcount[4:2];
	assign upper     = ~beam.vcount[4];
	assign col_left  = ~beam.hcount[4] & (beam.hcount[3:2] == 2'h0);
	assign col_right = ~beam.hcount[4] & (beam.hcount[3:2] == 2'h3);

	assign pixel_c = ~beam.hcount[4] & (
		(seg_c[6] & (row == 3'h0)) |
		(seg_c[5] & col_right & upper) |
		(seg_c[4] & col_right & ~upper) |
		(seg_c[3] & (row == 3'h7)) |
		(seg_c[2] & col_left & ~upper) |
		(seg_c[1] & col_left & upper) |
		(seg_c[0] & (row == 3'h4)));

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			seg          <= `GSC_SEG_OFF;
			score_window <= 1'b0;
			score_video  <= 1'b0;
		end else begin
			seg          <= seg_c;
			score_window <= window_c;
			score_video  <= pixel_c | net_video;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_capture;
		trail_strobe && demo_mode |=> pending_reg;
	endproperty
	a_capture: assert property (p_capture) else $error("pending flag not set on trailing edge");

	property p_transfer;
		vbit_rise && pending_reg |=> game_start;
	endproperty
	a_transfer: assert property (p_transfer) else $error("start not taken at vertical bit edge");

	property p_no_start_without_edge;
		!vbit_rise |=> $stable(start_reg);
	endproperty
	a_no_start_without_edge: assert property (p_no_start_without_edge) else $error("start moved off edge");

	property p_pending_clear;
		start_reg && !trail_strobe |=> !pending_reg;
	endproperty
	a_pending_clear: assert property (p_pending_clear) else $error("pending flag survived start");

	property p_play;
		start_rise && credit_s && !over_rise |=> play_mode && !demo_mode;
	endproperty
	a_play: assert property (p_play) else $error("play mode not entered");

	property p_demo;
		over_rise |=> demo_mode && !play_mode;
	endproperty
	a_demo: assert property (p_demo) else $error("demo mode not restored at game over");

	property p_window;
		!window_c |=> (seg == `GSC_SEG_OFF) && !score_window;
	endproperty
	a_window: assert property (p_window) else $error("segments outside score window");

	property p_clear;
		start_rise |=> (left_score == '0) && (right_score == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("scores not cleared on start");

	property p_wrap;
		left_point && !start_rise && left_score.units == `GSC_UNITS_MAX
			|=> left_score.units == `GSC_UNITS_ZERO && left_score.tens_flag != $past(left_score.tens_flag);
	endproperty
	a_wrap: assert property (p_wrap) else $error("tens flag not toggled at wrap");

	property p_limit;
		left_score.tens_flag && !limit_s && left_score.units == `GSC_LIMIT_LOW_U |=> game_over;
	endproperty
	a_limit: assert property (p_limit) else $error("game over missing at eleven");

	property p_net;
		net_video |=> score_video;
	endproperty
	a_net: assert property (p_net) else $error("net video lost");

	c_start: cover property (trail_strobe ##[1:1000] game_start);
	c_tens:  cover property (left_point && left_score.units == `GSC_UNITS_MAX);
	c_over:  cover property (over_rise ##1 demo_mode);
endmodule

// ### hw/gsc_consts.svh
// Constants for the game start and score control block
`ifndef GSC_CONSTS_SVH
`define GSC_CONSTS_SVH

`define GSC_CNT_W          9
`define GSC_LEFT_H_START   9'h080
`define GSC_LEFT_H_END     9'h0C0
`define GSC_RIGHT_H_START  9'h140
`define GSC_RIGHT_H_END    9'h18A
`define GSC_SCORE_V_START  9'h020
`define GSC_SCORE_V_END    9'h040
`define GSC_VSTART_BIT     8
`define GSC_SEL_LO_BIT     5
`define GSC_SEL_HI_BIT     6
`define GSC_UNITS_MAX      4'h9
`define GSC_UNITS_ZERO     4'h0
`define GSC_TENS_ONE       4'h1
`define GSC_TENS_BLANK     4'hF
`define GSC_LIMIT_LOW_U    4'h1
`define GSC_LIMIT_HIGH_U   4'h5
`define GSC_SEG_OFF        7'h00

`endif

// ### hw/gsc_pkg.sv
// Types shared by the game start and score control block
package gsc_pkg;
	typedef enum logic {
		GSC_PLAY = 1'b0,
		GSC_DEMO = 1'b1
	} gsc_mode_t;

	typedef enum logic [1:0] {
		GSC_SEL_LEFT_TENS   = 2'b00,
		GSC_SEL_LEFT_UNITS  = 2'b01,
		GSC_SEL_RIGHT_TENS  = 2'b10,
		GSC_SEL_RIGHT_UNITS = 2'b11
	} gsc_digit_sel_t;

	typedef struct packed {
		logic       tens_flag;
		logic [3:0] units;
	} gsc_score_t;

	typedef struct packed {
		logic [8:0] hcount;
		logic [8:0] vcount;
	} gsc_beam_t;
endpackage

// ### hw/gsc_sync.sv
// Two-stage synchroniser for asynchronous level inputs
module gsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end
endmodule

// ### hw/gsc_score.sv
// One player score: BCD units, tens flag, limit detector
`include "gsc_consts.svh"
module gsc_score (
	input  wire logic               ref_clk,
	input  wire logic               reset,
	input  wire logic               clear,
	input  wire logic               point,
	input  wire logic               limit_high,
	output gsc_pkg::gsc_score_t     score,
	output logic          [3:0]     tens_code,
	output logic                    limit_hit
);
	// Clear has priority: a point in the start cycle belongs to no game
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			score <= '0;
		end else if (clear) begin
			score <= '0;
		end else if (point) begin
			if (score.units == `GSC_UNITS_MAX) begin
				score.units     <= `GSC_UNITS_ZERO;
				score.tens_flag <= ~score.tens_flag;
			end else begin
				score.units <= score.units + 4'h1;
			end
		end
	end

	assign tens_code = score.tens_flag ? `GSC_TENS_ONE : `GSC_TENS_BLANK;

	assign limit_hit = score.tens_flag &&
		(score.units == (limit_high ? `GSC_LIMIT_HIGH_U : `GSC_LIMIT_LOW_U));
endmodule

// ### verif/gsc_beam_model.sv
// Video beam counter model feeding the score overlay
module gsc_beam_model #(
	parameter int H_TOTAL = 455,
	parameter int V_TOTAL = 262
) (
	input  wire logic               ref_clk,
	input  wire logic               reset,
	input  wire logic               run,
	input  wire logic               load,
	input  wire gsc_pkg::gsc_beam_t load_val,
	output gsc_pkg::gsc_beam_t      beam
);
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////
	// Load jumps the beam, run scans it like the sync chain
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			beam <= '0;
		end else if (load) begin
			beam <= load_val;
		end else if (run) begin
			if (beam.hcount == 9'(H_TOTAL - 1)) begin
				beam.hcount <= '0;
				beam.vcount <= (beam.vcount == 9'(V_TOTAL - 1)) ? 9'h000 : beam.vcount + 9'h001;
			end else begin
				beam.hcount <= beam.hcount + 9'h001;
			end
		end
	end
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the game start and score control block
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [8:0] h;
		logic [8:0] v;
		logic       net;
		logic       win;
		logic [6:0] seg;
		logic       vid;
	} gsc_row_t;

	localparam int N_ROWS = 15;
	// Scores are zero here: tens blank, units show 0
	localparam gsc_row_t ROWS [N_ROWS] = '{
		'{9'h07F, 9'h028, 1'h0, 1'h0, 7'h00, 1'h0},
		'{9'h080, 9'h028, 1'h1, 1'h1, 7'h00, 1'h1},
		'{9'h0BF, 9'h028, 1'h0, 1'h1, 7'h7E, 1'h0},
		'{9'h0C0, 9'h028, 1'h0, 1'h0, 7'h00, 1'h0},
		'{9'h13F, 9'h028, 1'h0, 1'h0, 7'h00, 1'h0},
		'{9'h140, 9'h028, 1'h0, 1'h1, 7'h00, 1'h0},
		'{9'h189, 9'h028, 1'h0, 1'h1, 7'h00, 1'h0},
		'{9'h18A, 9'h028, 1'h1, 1'h0, 7'h00, 1'h1},
		'{9'h0A0, 9'h01F, 1'h0, 1'h0, 7'h00, 1'h0},
		'{9'h0A0, 9'h020, 1'h1, 1'h1, 7'h7E, 1'h1},
		'{9'h0A0, 9'h024, 1'h0, 1'h1, 7'h7E, 1'h1},
		'{9'h0A4, 9'h024, 1'h0, 1'h1, 7'h7E, 1'h0},
		'{9'h0A0, 9'h03F, 1'h1, 1'h1, 7'h7E, 1'h1},
		'{9'h0A0, 9'h040, 1'h0, 1'h0, 7'h00, 1'h0},
		'{9'h160, 9'h028, 1'h1, 1'h1, 7'h7E, 1'h1}
	};

	logic               ref_clk;
	logic               reset;
	logic               btn_make_n;
	logic               btn_break_n;
	logic               credit_ok;
	logic               point_vs_right;
	logic               point_vs_left;
	logic               limit_closed;
	logic               net_video;
	logic               run;
	logic               load;
	gsc_pkg::gsc_beam_t load_val;
	gsc_pkg::gsc_beam_t beam;
	logic               game_start;
	logic               demo_mode;
	logic               play_mode;
	logic               game_over;
	logic               score_window;
	logic         [6:0] seg;
	logic               score_video;
	int                 n_fail;
	int                 check_count;

	gsc_beam_model i_beam (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.run      (run),
		.load     (load),
		.load_val (load_val),
		.beam     (beam)
	);

	gsc_top i_dut (
		.ref_clk        (ref_clk),
		.reset          (reset),
		.btn_make_n     (btn_make_n),
		.btn_break_n    (btn_break_n),
		.credit_ok      (credit_ok),
		.point_vs_right (point_vs_right),
		.point_vs_left  (point_vs_left),
		.limit_closed   (limit_closed),
		.beam           (beam),
		.net_video      (net_video),
		.game_start     (game_start),
		.demo_mode      (demo_mode),
		.play_mode      (play_mode),
		.game_over      (game_over),
		.score_window   (score_window),
		.seg            (seg),
		.score_video    (score_video)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %b", $time, what, got);
		end
	endtask

	task automatic chk_seg(input logic [6:0] got, input logic [6:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s seg %h want %h", $time, what, got, exp);
		end
	endtask

	// Park the beam and let the registered overlay settle
	task automatic show(input logic [8:0] h, input logic [8:0] v, input logic net);
		run = 1'b0;
		net_video = net;
		load_val = '{hcount: h, vcount: v};
		load = 1'b1;
		cyc(1);
		load = 1'b0;
		cyc(1);
	endtask

	// Jump just ahead of vertical count bit 8 rising and scan on
	task automatic go_vsync();
		load_val = '{hcount: 9'h1C0, vcount: 9'h0FF};
		load = 1'b1;
		cyc(1);
		load = 1'b0;
		run = 1'b1;
	endtask

	task automatic press();
		btn_make_n = 1'b0;
		btn_break_n = 1'b1;
		cyc(4);
		btn_make_n = 1'b1;
		btn_break_n = 1'b0;
		cyc(6);
	endtask

	task automatic pulse(input logic right_side, input int n);
		repeat (n) begin
			if (right_side) point_vs_left = 1'b1; else point_vs_right = 1'b1;
			cyc(3);
			point_vs_left = 1'b0;
			point_vs_right = 1'b0;
			cyc(3);
		end
	endtask

	task automatic wait_start();
		int k;
		k = 0;
		while (game_start !== 1'b1 && k < 2000) begin
			cyc(1);
			k++;
		end
		if (k >= 2000) begin
			n_fail++;
			$display("unexpected at %0t: start never came", $time);
			end_sim();
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		n_fail = 0;
		check_count = 0;
		reset = 1'b1;
		btn_make_n = 1'b1;
		btn_break_n = 1'b0;
		credit_ok = 1'b0;
		point_vs_right = 1'b0;
		point_vs_left = 1'b0;
		limit_closed = 1'b1;
		net_video = 1'b0;
		run = 1'b0;
		load = 1'b0;
		load_val = '0;
		repeat (12) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		chk_bit(game_start, 1'b0, "reset start");
		chk_bit(demo_mode, 1'b1, "reset demo");
		chk_bit(play_mode, 1'b0, "reset play");
		chk_bit(game_over, 1'b0, "reset over");
		chk_seg(seg, 7'h00, "reset");

		for (int i = 0; i < N_ROWS; i++) begin
			show(ROWS[i].h, ROWS[i].v, ROWS[i].net);
			chk_bit(score_window, ROWS[i].win, "window");
			chk_seg(seg, ROWS[i].seg, "row");
			chk_bit(score_video, ROWS[i].vid, "video");
		end

		// No credit: press gives nothing, demo points ignored
		press();
		pulse(1'b0, 2);
		go_vsync();
		cyc(20);
		chk_bit(game_start, 1'b0, "start without credit");
		credit_ok = 1'b1;
		press();
		cyc(10);
		chk_bit(game_start, 1'b0, "start before vsync");
		go_vsync();
		wait_start();
		chk_bit(beam.vcount[8], 1'b1, "start timing");
		cyc(3);
		chk_bit(play_mode, 1'b1, "play");
		chk_bit(demo_mode, 1'b0, "not demo");
		show(9'h0A0, 9'h028, 1'b0);
		chk_seg(seg, 7'h7E, "demo points");

		// Scoring, tens carry, right side, limit selector
		pulse(1'b0, 5);
		show(9'h0A0, 9'h028, 1'b0);
		chk_seg(seg, 7'h5B, "left five");
		pulse(1'b0, 5);
		show(9'h080, 9'h028, 1'b0);
		chk_seg(seg, 7'h30, "left tens");
		show(9'h0A0, 9'h028, 1'b0);
		chk_seg(seg, 7'h7E, "left wrap");
		pulse(1'b1, 3);
		show(9'h160, 9'h028, 1'b0);
		chk_seg(seg, 7'h79, "right three");
		pulse(1'b0, 1);
		cyc(5);
		chk_bit(game_over, 1'b0, "closed at eleven");
		limit_closed = 1'b0;
		cyc(6);
		chk_bit(game_over, 1'b1, "open at eleven");
		chk_bit(demo_mode, 1'b1, "back to demo");
		chk_bit(play_mode, 1'b0, "play ends");
		pulse(1'b0, 1);
		show(9'h0A0, 9'h028, 1'b0);
		chk_seg(seg, 7'h30, "demo point ignored");

		// Pending flag was cleared: next frame drops start
		show(9'h000, 9'h000, 1'b0);
		go_vsync();
		cyc(20);
		chk_bit(game_start, 1'b0, "single start");
		chk_bit(demo_mode, 1'b1, "no restart");

		// Second game clears both digits of the score
		press();
		go_vsync();
		wait_start();
		cyc(3);
		chk_bit(play_mode, 1'b1, "second play");
		chk_bit(game_over, 1'b0, "over cleared");
		show(9'h080, 9'h028, 1'b0);
		chk_seg(seg, 7'h00, "tens cleared");
		show(9'h0A0, 9'h028, 1'b0);
		chk_seg(seg, 7'h7E, "units cleared");
		end_sim();
	end
endmodule
